// ===== src/pcg_gate_bank.sv
// Purpose: registered clock enables and access checking for all units
// Assumes: accesses are single-cycle pulses with a unit index
// Notes: the check uses the enable the unit actually has this cycle
`timescale 1ns/1ps
`default_nettype none

module pcg_gate_bank (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control side
    pcg_gate_if.bank gate
);
    import pcg_pkg::*;

    pcg_units_t clk_en_r;
    logic fault_r;
    logic grant_r;
    logic idx_ok;
    logic unit_on;

    assign idx_ok = (gate.index <= PCG_UNIT_LAST);
    assign unit_on = idx_ok && clk_en_r[gate.index];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en_r <= '0; // RULE_03
        end else begin
            clk_en_r <= gate.want_en; // RULE_01
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_r <= 1'b0;
            grant_r <= 1'b0;
        end else begin
            fault_r <= gate.access && !unit_on; // RULE_02
            grant_r <= gate.access && unit_on;
        end
    end

    assign gate.clk_en = clk_en_r;
    assign gate.fault = fault_r;
    assign gate.grant = grant_r;

endmodule

`default_nettype wire

// ===== src/pcg_gate_if.sv
// Purpose: carrier between the gating control and the gate bank
// Assumes: one clock domain
// Notes: ctrl side selects enables and forwards unit accesses
`timescale 1ns/1ps
`default_nettype none

interface pcg_gate_if;
    import pcg_pkg::*;

    pcg_units_t want_en;
    logic access;
    logic [3:0] index;
    pcg_units_t clk_en;
    logic fault;
    logic grant;

    modport ctrl (
        output want_en,
        output access,
        output index,
        input clk_en,
        input fault,
        input grant
    );

    modport bank (
        input want_en,
        input access,
        input index,
        output clk_en,
        output fault,
        output grant
    );
endinterface

`default_nettype wire

// ===== src/pcg_pkg.sv
// Purpose: constants and types shared by the peripheral clock gating block
// Assumes: APB register bus with 32-bit data, 12-bit byte address
// Notes: unit index 0..4 are ports A..E, 5 timer 0, 6 sync serial 0,
//        7 serial port 0, 8 serial port 1
//
// Overview of operation
// (RULE_01) A unit whose gating bit is one gets its clock enable, a zero stops and disables it.
// (RULE_02) Any access aimed at a unit whose clock is off is answered with a fault, not a completion.
// (RULE_03) Every gating bit is zero after reset, so all units start unclocked.
// (RULE_04) Software sets the gating bits of the ports it needs before it uses them.
// (RULE_05) Run registers apply while running, sleep registers in sleep, deep-sleep registers in deep sleep.
// (RULE_06) Sleep and deep-sleep registers apply only while the auto clock gating bit is set.
// (RULE_07) Bits 0 to 4 of the run and sleep port registers gate ports A to E, read/write.
// (RULE_08) Bit 16 of the deep-sleep peripheral register gates timer 0 in deep sleep.
// (RULE_09) Bit 4 of the deep-sleep peripheral register gates sync serial 0 in deep sleep.
// (RULE_10) Bits 1 and 0 of the deep-sleep peripheral register gate serial ports 1 and 0.
// (RULE_11) Reserved bits are read-only, read zero, and software keeps them on updates.
// (RULE_12) Bit positions with no unit behind them behave as reserved.
// (RULE_13) The run port register resets to all zeros as a whole and is read/write.
// (RULE_14) The deep-sleep port register holds ports A to E at bits 0 to 4.
// (RULE_15) Without auto clock gating the run registers stay in force in sleep and deep sleep.

package pcg_pkg;

    localparam int PCG_AW = 12;
    localparam int PCG_DW = 32;
    localparam int PCG_NUNITS = 9;

    typedef logic [PCG_NUNITS-1:0] pcg_units_t;
    typedef logic [PCG_DW-1:0] pcg_word_t;
    typedef logic [PCG_AW-1:0] pcg_addr_t;

    typedef enum logic [1:0] {
        PCG_RUN,
        PCG_SLEEP,
        PCG_DEEP
    } pcg_power_e;

    // register byte offsets
    localparam pcg_addr_t PCG_OFF_RUN_PORT = 12'h108;
    localparam pcg_addr_t PCG_OFF_SLEEP_PORT = 12'h118;
    localparam pcg_addr_t PCG_OFF_DEEP_PERIPH = 12'h124;
    localparam pcg_addr_t PCG_OFF_DEEP_PORT = 12'h128;
    localparam pcg_addr_t PCG_OFF_RUN_PERIPH = 12'h1E0;
    localparam pcg_addr_t PCG_OFF_SLEEP_PERIPH = 12'h1E4;
    localparam pcg_addr_t PCG_OFF_RUN_CLOCK_CONFIG = 12'h1E8;
    localparam pcg_addr_t PCG_OFF_STATUS = 12'h1EC;
    localparam pcg_addr_t PCG_OFF_FAULT_COUNT = 12'h1F0;

    // writable bit masks, everything else reads zero
    localparam pcg_word_t PCG_PORT_MASK = 32'h0000001F;
    localparam pcg_word_t PCG_PERIPH_MASK = 32'h00010013;
    localparam pcg_word_t PCG_CLOCK_CONFIG_MASK = 32'h00000001;
    localparam pcg_word_t PCG_RESET_VALUE = 32'h00000000;

    // field positions
    localparam int PCG_PORT_LSB = 0;
    localparam int PCG_BIT_SERIAL0 = 0;
    localparam int PCG_BIT_SERIAL1 = 1;
    localparam int PCG_BIT_SYNC0 = 4;
    localparam int PCG_BIT_GP_TIMER_ZERO_CLOCK_EN = 16;
    localparam int PCG_BIT_AUTO_GATE = 0;
    localparam int PCG_STAT_MODE_LSB = 16;
    localparam int PCG_STAT_AUTO_BIT = 20;

    // unit indices on the access side
    localparam logic [3:0] PCG_UNIT_GP_TIMER_ZERO_CLOCK_EN = 4'h5;
    localparam logic [3:0] PCG_UNIT_LAST = 4'h8;

endpackage

// ===== src/pcg_top.sv
// Purpose: peripheral clock gating control with APB register access
// Assumes: power mode requests are synchronous levels from the core
// Notes: outputs are clock enables; the cell that gates each clock
//        sits next to the unit it feeds
`timescale 1ns/1ps
`default_nettype none

module pcg_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire pcg_pkg::pcg_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire pcg_pkg::pcg_word_t pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power mode requests
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    output logic [1:0] power_state,
    // unit access check
    input wire logic unit_access,
    input wire logic [3:0] unit_index,
    output logic unit_grant,
    output logic unit_fault,
    // unit clock enables
    output pcg_pkg::pcg_units_t unit_clk_en
);
    import pcg_pkg::*;

    pcg_gate_if gate ();

    // register state
    pcg_word_t run_port_clock_gate_r;
    pcg_word_t sleep_port_clock_gate_r;
    pcg_word_t deep_sleep_port_clock_gate_r;
    pcg_word_t deep_sleep_periph_clock_gate_r;
    pcg_word_t run_periph_clock_gate_r;
    pcg_word_t sleep_periph_clock_gate_r;
    pcg_word_t run_clock_config_r;
    pcg_word_t fault_count_r;
    pcg_power_e power_r;
    pcg_power_e power_nxt;

    // apb answer state
    logic pready_r;
    logic pslverr_r;
    pcg_word_t prdata_r;

    // apb phase decode
    logic setup_ph;
    logic done_ph;
    logic wr_done;

    assign setup_ph = psel && !penable;
    assign done_ph = psel && penable && pready_r;
    assign wr_done = done_ph && pwrite;

    // address decode
    logic hit_run_port;
    logic hit_sleep_port;
    logic hit_deep_port;
    logic hit_deep_periph;
    logic hit_run_periph;
    logic hit_sleep_periph;
    logic hit_clock_config;
    logic hit_status;
    logic hit_fault_count;
    logic hit_any;

    assign hit_run_port = (paddr == PCG_OFF_RUN_PORT);
    assign hit_sleep_port = (paddr == PCG_OFF_SLEEP_PORT);
    assign hit_deep_port = (paddr == PCG_OFF_DEEP_PORT);
    assign hit_deep_periph = (paddr == PCG_OFF_DEEP_PERIPH);
    assign hit_run_periph = (paddr == PCG_OFF_RUN_PERIPH);
    assign hit_sleep_periph = (paddr == PCG_OFF_SLEEP_PERIPH);
    assign hit_clock_config = (paddr == PCG_OFF_RUN_CLOCK_CONFIG);
    assign hit_status = (paddr == PCG_OFF_STATUS);
    assign hit_fault_count = (paddr == PCG_OFF_FAULT_COUNT);
    assign hit_any = hit_run_port || hit_sleep_port || hit_deep_port ||
        hit_deep_periph || hit_run_periph || hit_sleep_periph ||
        hit_clock_config || hit_status || hit_fault_count;

    // byte strobe merge, only writable bits may change
    function automatic pcg_word_t merge_wr(
        input pcg_word_t old,
        input pcg_word_t wdata,
        input logic [3:0] strb,
        input pcg_word_t mask
    );
        pcg_word_t lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge_wr = ((old & ~lanes) | (wdata & lanes)) & mask;
    endfunction

    // next values of the gating registers
    pcg_word_t run_port_nxt;
    pcg_word_t sleep_port_nxt;
    pcg_word_t deep_port_nxt;
    pcg_word_t deep_periph_nxt;
    pcg_word_t run_periph_nxt;
    pcg_word_t sleep_periph_nxt;
    pcg_word_t clock_config_nxt;

    assign run_port_nxt = merge_wr(run_port_clock_gate_r, pwdata, pstrb,
        PCG_PORT_MASK); // RULE_07
    assign sleep_port_nxt = merge_wr(sleep_port_clock_gate_r, pwdata, pstrb,
        PCG_PORT_MASK); // RULE_07
    assign deep_port_nxt = merge_wr(deep_sleep_port_clock_gate_r, pwdata,
        pstrb, PCG_PORT_MASK); // RULE_14
    assign deep_periph_nxt = merge_wr(deep_sleep_periph_clock_gate_r, pwdata,
        pstrb, PCG_PERIPH_MASK); // RULE_12
    assign run_periph_nxt = merge_wr(run_periph_clock_gate_r, pwdata, pstrb,
        PCG_PERIPH_MASK);
    assign sleep_periph_nxt = merge_wr(sleep_periph_clock_gate_r, pwdata,
        pstrb, PCG_PERIPH_MASK);
    assign clock_config_nxt = merge_wr(run_clock_config_r, pwdata, pstrb,
        PCG_CLOCK_CONFIG_MASK);

    // run port gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_port_clock_gate_r <= PCG_RESET_VALUE; // RULE_13
        end else if (wr_done && hit_run_port) begin
            run_port_clock_gate_r <= run_port_nxt; // RULE_13
        end
    end

    // sleep port gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_port_clock_gate_r <= PCG_RESET_VALUE; // RULE_03
        end else if (wr_done && hit_sleep_port) begin
            sleep_port_clock_gate_r <= sleep_port_nxt;
        end
    end

    // deep-sleep port gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep_port_clock_gate_r <= PCG_RESET_VALUE; // RULE_03
        end else if (wr_done && hit_deep_port) begin
            deep_sleep_port_clock_gate_r <= deep_port_nxt;
        end
    end

    // deep-sleep peripheral gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep_periph_clock_gate_r <= PCG_RESET_VALUE; // RULE_03
        end else if (wr_done && hit_deep_periph) begin
            deep_sleep_periph_clock_gate_r <= deep_periph_nxt;
        end
    end

    // run peripheral gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_periph_clock_gate_r <= PCG_RESET_VALUE; // RULE_03
        end else if (wr_done && hit_run_periph) begin
            run_periph_clock_gate_r <= run_periph_nxt;
        end
    end

    // sleep peripheral gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_periph_clock_gate_r <= PCG_RESET_VALUE; // RULE_03
        end else if (wr_done && hit_sleep_periph) begin
            sleep_periph_clock_gate_r <= sleep_periph_nxt;
        end
    end

    // run clock configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_clock_config_r <= PCG_RESET_VALUE;
        end else if (wr_done && hit_clock_config) begin
            run_clock_config_r <= clock_config_nxt;
        end
    end

    // power state follows the core's requests, deep sleep first
    always_comb begin
        if (deep_sleep_req) begin
            power_nxt = PCG_DEEP;
        end else if (sleep_req) begin
            power_nxt = PCG_SLEEP;
        end else begin
            power_nxt = PCG_RUN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_r <= PCG_RUN;
        end else begin
            power_r <= power_nxt;
        end
    end

    // unit vectors built from port and peripheral registers
    logic auto_clock_gating;
    pcg_units_t run_units;
    pcg_units_t sleep_units;
    pcg_units_t deep_units;
    pcg_units_t sel_units;

    assign auto_clock_gating = run_clock_config_r[PCG_BIT_AUTO_GATE];

    assign run_units = {
        run_periph_clock_gate_r[PCG_BIT_SERIAL1],
        run_periph_clock_gate_r[PCG_BIT_SERIAL0],
        run_periph_clock_gate_r[PCG_BIT_SYNC0],
        run_periph_clock_gate_r[PCG_BIT_GP_TIMER_ZERO_CLOCK_EN],
        run_port_clock_gate_r[PCG_PORT_LSB +: 5]
    }; // RULE_07
    assign sleep_units = {
        sleep_periph_clock_gate_r[PCG_BIT_SERIAL1],
        sleep_periph_clock_gate_r[PCG_BIT_SERIAL0],
        sleep_periph_clock_gate_r[PCG_BIT_SYNC0],
        sleep_periph_clock_gate_r[PCG_BIT_GP_TIMER_ZERO_CLOCK_EN],
        sleep_port_clock_gate_r[PCG_PORT_LSB +: 5]
    }; // RULE_07
    assign deep_units = {
        deep_sleep_periph_clock_gate_r[PCG_BIT_SERIAL1], // RULE_10
        deep_sleep_periph_clock_gate_r[PCG_BIT_SERIAL0], // RULE_10
        deep_sleep_periph_clock_gate_r[PCG_BIT_SYNC0], // RULE_09
        deep_sleep_periph_clock_gate_r[PCG_BIT_GP_TIMER_ZERO_CLOCK_EN], // RULE_08
        deep_sleep_port_clock_gate_r[PCG_PORT_LSB +: 5] // RULE_14
    };

    // register set in force for the current power state
    always_comb begin
        if (!auto_clock_gating) begin
            sel_units = run_units; // RULE_15
        end else begin
            case (power_r)
                PCG_RUN: begin
                    sel_units = run_units; // RULE_05
                end
                PCG_SLEEP: begin
                    sel_units = sleep_units; // RULE_06
                end
                PCG_DEEP: begin
                    sel_units = deep_units; // RULE_06
                end
                default: begin
                    sel_units = run_units;
                end
            endcase
        end
    end

    assign gate.want_en = sel_units; // RULE_05
    assign gate.access = unit_access;
    assign gate.index = unit_index;

    pcg_gate_bank u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .gate(gate.bank)
    );

    // faults on gated units are counted; a count wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_count_r <= PCG_RESET_VALUE;
        end else if (gate.fault) begin
            if (fault_count_r != 32'hFFFFFFFF) begin
                fault_count_r <= fault_count_r + 32'h00000001;
            end
        end else if (wr_done && hit_fault_count) begin
            fault_count_r <= PCG_RESET_VALUE;
        end
    end

    // status word: applied enables, power state, auto gating
    pcg_word_t status_word;

    always_comb begin
        status_word = PCG_RESET_VALUE;
        status_word[PCG_NUNITS-1:0] = gate.clk_en;
        status_word[PCG_STAT_MODE_LSB +: 2] = power_r;
        status_word[PCG_STAT_AUTO_BIT] = auto_clock_gating;
    end

    // read data select, reserved bits are already zero in storage
    pcg_word_t rd_word;

    always_comb begin
        rd_word = PCG_RESET_VALUE;
        if (hit_run_port) begin
            rd_word = run_port_clock_gate_r; // RULE_11
        end else if (hit_sleep_port) begin
            rd_word = sleep_port_clock_gate_r; // RULE_11
        end else if (hit_deep_port) begin
            rd_word = deep_sleep_port_clock_gate_r; // RULE_11
        end else if (hit_deep_periph) begin
            rd_word = deep_sleep_periph_clock_gate_r; // RULE_12
        end else if (hit_run_periph) begin
            rd_word = run_periph_clock_gate_r;
        end else if (hit_sleep_periph) begin
            rd_word = sleep_periph_clock_gate_r;
        end else if (hit_clock_config) begin
            rd_word = run_clock_config_r;
        end else if (hit_status) begin
            rd_word = status_word;
        end else if (hit_fault_count) begin
            rd_word = fault_count_r;
        end
    end

    // apb answer: ready in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= PCG_RESET_VALUE;
        end else if (setup_ph) begin
            pready_r <= 1'b1;
            pslverr_r <= !hit_any;
            prdata_r <= pwrite ? PCG_RESET_VALUE : rd_word;
        end else if (done_ph) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= PCG_RESET_VALUE;
        end
    end

    // output flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_state <= 2'h0;
        end else begin
            power_state <= power_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign unit_grant = gate.grant;
    assign unit_fault = gate.fault; // RULE_02
    assign unit_clk_en = gate.clk_en; // RULE_01

endmodule

`default_nettype wire

// ===== testbench/pcg_top_assertions.sv
// Purpose: concurrent checks on the clock gating top ports
// Assumes: one clock domain, reset active low
// Notes: attached to the top by the bind below the module
`timescale 1ns/1ps
`default_nettype none

module pcg_top_assertions
    import pcg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire pcg_pkg::pcg_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire pcg_pkg::pcg_word_t pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // power
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic [1:0] power_state,
    // units
    input wire logic unit_access,
    input wire logic [3:0] unit_index,
    input wire logic unit_grant,
    input wire logic unit_fault,
    input wire pcg_pkg::pcg_units_t unit_clk_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence run_wr_s;
        psel && penable && pready && pwrite && pstrb[0]
            && paddr == PCG_OFF_RUN_PORT;
    endsequence
    sequence run_held_s;
        power_state == 2'h0 && !sleep_req && !deep_sleep_req;
    endsequence
    sequence port_rd_s;
        pready && !pwrite && (paddr == PCG_OFF_RUN_PORT
            || paddr == PCG_OFF_SLEEP_PORT || paddr == PCG_OFF_DEEP_PORT);
    endsequence

    chk_grant_when_on: assert property (
        unit_access && unit_index <= PCG_UNIT_LAST && unit_clk_en[unit_index]
        |=> unit_grant && !unit_fault) else $error("grant missing");
    chk_fault_when_off: assert property (
        unit_access && (unit_index > PCG_UNIT_LAST || !unit_clk_en[unit_index])
        |=> unit_fault && !unit_grant) else $error("fault missing");
    chk_quiet_no_access: assert property (
        !unit_access |=> !unit_grant && !unit_fault)
        else $error("answer without access");
    chk_reset_all_off: assert property (
        $rose(presetn) |-> unit_clk_en == '0) else $error("enable after reset");
    chk_port_write_gates: assert property (
        run_wr_s and run_held_s |-> ##2 unit_clk_en[4:0] == $past(pwdata[4:0], 2))
        else $error("run port write not applied");
    chk_deep_state: assert property (
        deep_sleep_req |=> power_state == 2'h2) else $error("deep state wrong");
    chk_sleep_state: assert property (
        sleep_req && !deep_sleep_req |=> power_state == 2'h1)
        else $error("sleep state wrong");
    chk_ready_access: assert property (
        setup_s ##1 psel && penable |-> pready) else $error("pready late");
    chk_ready_pulse: assert property (
        pready |=> !pready) else $error("pready too long");
    chk_port_reserved: assert property (
        port_rd_s |-> prdata[31:5] == 27'h0) else $error("port reserved set");
    chk_periph_reserved: assert property (
        pready && !pwrite && paddr == PCG_OFF_DEEP_PERIPH
        |-> (prdata & ~PCG_PERIPH_MASK) == 32'h0) else $error("periph reserved");
endmodule

bind pcg_top pcg_top_assertions u_pcg_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .power_state(power_state), .unit_access(unit_access),
    .unit_index(unit_index), .unit_grant(unit_grant),
    .unit_fault(unit_fault), .unit_clk_en(unit_clk_en)
);

`default_nettype wire

// ===== testbench/pcg_top_tb_top.sv
// Purpose: self-checking bench for the clock gating top
// Assumes: apb slave answers in the first access cycle
// Notes: expected enables are built from the register layout
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end end

module pcg_top_tb_top;
    import pcg_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    pcg_addr_t paddr = '0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    pcg_word_t pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic sleep_req = 1'h0;
    logic deep_sleep_req = 1'h0;
    logic unit_access = 1'h0;
    logic [3:0] unit_index = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic unit_grant;
    logic unit_fault;
    logic [1:0] power_state;
    pcg_units_t unit_clk_en;
    int n_mismatch = 0;
    int checked = 0;
    pcg_word_t rdv;
    logic err;
    pcg_units_t e_run;
    pcg_units_t e_slp;
    pcg_units_t e_dp;
    pcg_addr_t regs [6] = '{PCG_OFF_RUN_PORT, PCG_OFF_SLEEP_PORT,
        PCG_OFF_DEEP_PORT, PCG_OFF_DEEP_PERIPH, PCG_OFF_RUN_PERIPH,
        PCG_OFF_SLEEP_PERIPH};
    pcg_word_t masks [6] = '{PCG_PORT_MASK, PCG_PORT_MASK, PCG_PORT_MASK,
        PCG_PERIPH_MASK, PCG_PERIPH_MASK, PCG_PERIPH_MASK};

    always #4 pclk = ~pclk;

    pcg_top dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .power_state(power_state), .unit_access(unit_access),
        .unit_index(unit_index), .unit_grant(unit_grant),
        .unit_fault(unit_fault), .unit_clk_en(unit_clk_en)
    );

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input pcg_addr_t a, input pcg_word_t d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        // pready, prdata and pslverr are read at the rising edge itself
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            n_mismatch++;
            $display("[ERR] pready expected 1 seen %b", pready);
            complete_run();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd_chk(input pcg_addr_t a, input pcg_word_t e);
        apb(1'h0, a, '0);
        `CHK("prdata", e, rdv)
    endtask

    // enables settle two edges after a write or a power request
    task automatic settle(input pcg_units_t e);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        `CHK("unit_clk_en", e, unit_clk_en)
        @(posedge pclk);
    endtask

    // one access per unit index, plus one index past the last unit
    task automatic probe(input pcg_units_t e);
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            unit_access <= 1'h1;
            unit_index <= 4'(i);
            @(posedge pclk);
            unit_access <= 1'h0;
            @(negedge pclk);
            `CHK("unit_grant", (i < 9) ? e[i] : 1'h0, unit_grant)
            `CHK("unit_fault", (i < 9) ? !e[i] : 1'h1, unit_fault)
        end
        @(posedge pclk);
    endtask

    function automatic pcg_units_t exp_en(input pcg_word_t pt,
        input pcg_word_t pe);
        return {pe[1], pe[0], pe[4], pe[16], pt[4:0]};
    endfunction

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        foreach (regs[i]) rd_chk(regs[i], PCG_RESET_VALUE);
        rd_chk(PCG_OFF_RUN_CLOCK_CONFIG, PCG_RESET_VALUE);
        rd_chk(12'h000, 32'h0);
        `CHK("pslverr", 1'h1, err)
        foreach (regs[i]) begin
            apb(1'h1, regs[i], 32'hFFFFFFFF);
            rd_chk(regs[i], masks[i]);
        end
        settle(exp_en(32'h1F, PCG_PERIPH_MASK));
        apb(1'h1, PCG_OFF_RUN_PORT, 32'h15);
        apb(1'h1, PCG_OFF_RUN_PERIPH, 32'h00010001);
        e_run = exp_en(32'h15, 32'h00010001);
        settle(e_run);
        probe(e_run);
        rd_chk(PCG_OFF_FAULT_COUNT, 32'h5);
        apb(1'h1, PCG_OFF_FAULT_COUNT, '0);
        apb(1'h1, PCG_OFF_SLEEP_PORT, 32'h0A);
        apb(1'h1, PCG_OFF_SLEEP_PERIPH, 32'h12);
        apb(1'h1, PCG_OFF_DEEP_PORT, 32'h04);
        apb(1'h1, PCG_OFF_DEEP_PERIPH, 32'h00010000);
        e_slp = exp_en(32'h0A, 32'h12);
        e_dp = exp_en(32'h04, 32'h00010000);
        sleep_req <= 1'h1;
        settle(e_run);
        deep_sleep_req <= 1'h1;
        settle(e_run);
        apb(1'h1, PCG_OFF_RUN_CLOCK_CONFIG, 32'h1);
        settle(e_dp);
        probe(e_dp);
        rd_chk(PCG_OFF_FAULT_COUNT, 32'h8);
        deep_sleep_req <= 1'h0;
        settle(e_slp);
        rd_chk(PCG_OFF_STATUS, 32'h00110000 | 32'(e_slp));
        sleep_req <= 1'h0;
        settle(e_run);
        @(posedge pclk);
        presetn <= 1'h0;
        @(negedge pclk);
        `CHK("unit_clk_en", 9'h000, unit_clk_en)
        @(posedge pclk);
        presetn <= 1'h1;
        rd_chk(PCG_OFF_RUN_PORT, PCG_RESET_VALUE);
        complete_run();
    end
endmodule

`default_nettype wire
